/* File: ode_regs.vh */
// Widths, field positions and buffer constants of the on-die ECC datapath
`ifndef ODE_REGS_VH
`define ODE_REGS_VH

`define ODE_PIN_W      32
`define ODE_WORD_W     64
`define ODE_CHK_W      8
`define ODE_CW_W       72
`define ODE_SYN_W      7
`define ODE_POS_LAST   71
`define ODE_ENT_W      34
`define ODE_FLG_COR    32
`define ODE_FLG_UNC    33
`define ODE_ADDR_W     24
`define ODE_BUF_DEPTH  2
`define ODE_CNT_W      2
`define ODE_CNT_ZERO   2'h0
`define ODE_CNT_ONE    2'h1
`define ODE_CNT_TWO    2'h2
`define ODE_ST_W       3

`endif

/* File: ode_mem.v */
// Codeword array: one write port, one read port with registered read data
`timescale 1ns/100ps
module ode_mem #(
  parameter AW = 23,
  parameter DW = 72
) (
  input  wire          core_clk_i,
  input  wire          rst_n_i,
  input  wire          wr_en_i,
  input  wire [AW-1:0] wr_addr_i,
  input  wire [DW-1:0] wr_data_i,
  input  wire          rd_en_i,
  input  wire [AW-1:0] rd_addr_i,
  output wire [DW-1:0] rd_data_o
);

  reg [DW-1:0] mem_r [0:(1<<AW)-1];
  reg [DW-1:0] rd_data_r;

  ////////////////////////////////////////////////////////////////////////////
  // Array write
  always @(posedge core_clk_i)
  begin
    if (wr_en_i)
    begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered read: holds the whole codeword before correction
  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_r <= {DW{1'b0}};
    end
    else if (rd_en_i)
    begin
      rd_data_r <= mem_r[rd_addr_i];
    end
  end

  assign rd_data_o = rd_data_r;

endmodule // ode_mem

/* File: ode_ecc_datapath.v */
// On-die ECC datapath: check-bit generation, storage and read correction
`timescale 1ns/100ps
`include "ode_regs.vh"

// Overview of operation
// - Writes store eight check bits per word
// - Reads buffer full 72-bit codeword first
// - Hamming code, 72 bits protecting 64
// - Any single flipped bit gets repaired
// - Coding adds cycles only to lone half writes (RMW)
// - Only 32 corrected data bits leave
// - Everything on rising edge of one clock
// - Correction always on, no disable
// - Corrected read data written back only by RMW merges
module ode_ecc_datapath #(
  parameter ADDR_W = `ODE_ADDR_W
) (
  input  wire              core_clk_i,
  input  wire              rst_n_i,
  input  wire              wr_valid_i,
  output wire              wr_ready_o,
  input  wire [ADDR_W-1:0] wr_addr_i,
  input  wire [`ODE_PIN_W-1:0] wr_data_i,
  input  wire              rd_valid_i,
  output wire              rd_ready_o,
  input  wire [ADDR_W-1:0] rd_addr_i,
  output wire [`ODE_PIN_W-1:0] rd_data_o,
  output wire              rd_corr_o,
  output wire              rd_uncorr_o,
  output wire              rd_data_valid_o,
  input  wire              rd_data_ready_i
);

  localparam PW = ADDR_W - 1;
  localparam [`ODE_ST_W-1:0] ST_IDLE = 3'h0;
  localparam [`ODE_ST_W-1:0] ST_HALF = 3'h1;
  localparam [`ODE_ST_W-1:0] ST_RMWR = 3'h2;
  localparam [`ODE_ST_W-1:0] ST_RMWW = 3'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Check-bit generator
  function [`ODE_CHK_W-1:0] ode_enc;
    input [`ODE_WORD_W-1:0] d;
    integer i, j;
    reg [`ODE_SYN_W-1:0] s;
  begin
    s = {`ODE_SYN_W{1'b0}};
    j = 0;
    for (i = 1; i <= `ODE_POS_LAST; i = i + 1)
    begin
      if ((i & (i - 1)) != 0)
      begin
        s = s ^ (i[`ODE_SYN_W-1:0] & {`ODE_SYN_W{d[j]}});
        j = j + 1;
      end
    end
    ode_enc = {(^d) ^ (^s), s};
  end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Corrector: returns {uncorrectable, corrected, data}
  function [`ODE_WORD_W+1:0] ode_dec;
    input [`ODE_CW_W-1:0] cw;
    integer i, j;
    reg [`ODE_SYN_W-1:0] s;
    reg [`ODE_CHK_W-1:0] e;
    reg [`ODE_WORD_W-1:0] d;
    reg par;
  begin
    d = cw[`ODE_WORD_W-1:0];
    e = ode_enc(d);
    s = cw[`ODE_WORD_W+`ODE_SYN_W-1:`ODE_WORD_W] ^ e[`ODE_SYN_W-1:0];
    par = ^cw;
    j = 0;
    for (i = 1; i <= `ODE_POS_LAST; i = i + 1)
    begin
      if ((i & (i - 1)) != 0)
      begin
        d[j] = d[j] ^ (par && (s == i[`ODE_SYN_W-1:0]));
        j = j + 1;
      end
    end
    ode_dec = {(~par) & (s != {`ODE_SYN_W{1'b0}}), par, d};
  end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and buffers
  reg [`ODE_ST_W-1:0]   st_r;
  reg [`ODE_ST_W-1:0]   st_nxt;
  reg [`ODE_PIN_W-1:0]  hold_data_r;
  reg [`ODE_PIN_W-1:0]  hold_data_nxt;
  reg [PW-1:0]          hold_pair_r;
  reg [PW-1:0]          hold_pair_nxt;
  reg                   hold_hi_r;
  reg                   hold_hi_nxt;
  reg                   rep_v_r;
  reg                   rep_v_nxt;
  reg [ADDR_W-1:0]      rep_addr_r;
  reg [ADDR_W-1:0]      rep_addr_nxt;
  reg [`ODE_PIN_W-1:0]  rep_data_r;
  reg [`ODE_PIN_W-1:0]  rep_data_nxt;
  reg                   rsp_pend_r;
  reg                   rsp_half_r;
  reg                   wr_ready_r;
  reg                   wr_ready_nxt;
  reg                   rd_ready_r;
  reg                   rd_ready_nxt;
  reg [`ODE_ENT_W-1:0]  q0_r;
  reg [`ODE_ENT_W-1:0]  q0_nxt;
  reg [`ODE_ENT_W-1:0]  q1_r;
  reg [`ODE_ENT_W-1:0]  q1_nxt;
  reg [`ODE_CNT_W-1:0]  cnt_r;
  reg [`ODE_CNT_W-1:0]  cnt_nxt;
  reg                   dv_r;
  reg                   mem_we;
  reg [PW-1:0]          mem_wa;
  reg [`ODE_CW_W-1:0]   mem_wd;
  reg                   mem_re;
  reg [PW-1:0]          mem_ra;
  reg [`ODE_WORD_W-1:0] merged;
  reg                   w_v;
  reg [ADDR_W-1:0]      w_addr;
  reg [`ODE_PIN_W-1:0]  w_data;
  reg [`ODE_ENT_W-1:0]  rsp_ent;
  wire [`ODE_CW_W-1:0]  mem_rd;
  wire [`ODE_WORD_W+1:0] dec;
  wire                  wr_take;
  wire                  rd_take;
  wire                  push;
  wire                  pop;
  wire [`ODE_WORD_W-1:0] full_word;

  assign wr_take   = wr_valid_i & wr_ready_r;
  assign rd_take   = rd_valid_i & rd_ready_r;
  assign push      = rsp_pend_r;
  assign pop       = dv_r & rd_data_ready_i;
  assign full_word = {wr_data_i, hold_data_r};
  // Correction sits on the registered array output, no extra stage
  assign dec       = ode_dec(mem_rd);

  ode_mem #(
    .AW (PW),
    .DW (`ODE_CW_W)
  ) u_mem (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .wr_en_i    (mem_we),
    .wr_addr_i  (mem_wa),
    .wr_data_i  (mem_wd),
    .rd_en_i    (mem_re),
    .rd_addr_i  (mem_ra),
    .rd_data_o  (mem_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write pairing and read-modify-write control
  always @*
  begin
    st_nxt        = st_r;
    hold_data_nxt = hold_data_r;
    hold_pair_nxt = hold_pair_r;
    hold_hi_nxt   = hold_hi_r;
    rep_v_nxt     = rep_v_r;
    rep_addr_nxt  = rep_addr_r;
    rep_data_nxt  = rep_data_r;
    mem_we        = 1'b0;
    mem_wa        = hold_pair_r;
    mem_wd        = {`ODE_CW_W{1'b0}};
    mem_re        = 1'b0;
    mem_ra        = hold_pair_r;
    merged        = {`ODE_WORD_W{1'b0}};
    w_v           = rep_v_r | wr_take;
    w_addr        = rep_v_r ? rep_addr_r : wr_addr_i;
    w_data        = rep_v_r ? rep_data_r : wr_data_i;
    case (st_r)
      ST_IDLE:
      begin
        if (rd_take)
        begin
          mem_re = 1'b1;
          mem_ra = rd_addr_i[ADDR_W-1:1];
        end
        if (w_v)
        begin
          rep_v_nxt     = 1'b0;
          hold_data_nxt = w_data;
          hold_pair_nxt = w_addr[ADDR_W-1:1];
          hold_hi_nxt   = w_addr[0];
          st_nxt        = w_addr[0] ? ST_RMWR : ST_HALF;
        end
      end
      ST_HALF:
      begin
        if (wr_take && (wr_addr_i == {hold_pair_r, 1'b1}))
        begin
          mem_we = 1'b1;
          mem_wd = {ode_enc(full_word), full_word};
          st_nxt = ST_IDLE;
        end
        else
        begin
          mem_re = 1'b1;
          st_nxt = ST_RMWW;
          if (wr_take)
          begin
            rep_v_nxt    = 1'b1;
            rep_addr_nxt = wr_addr_i;
            rep_data_nxt = wr_data_i;
          end
        end
      end
      ST_RMWR:
      begin
        mem_re = 1'b1;
        st_nxt = ST_RMWW;
      end
      ST_RMWW:
      begin
        merged = hold_hi_r ? {hold_data_r, dec[`ODE_PIN_W-1:0]} :
                             {dec[`ODE_WORD_W-1:`ODE_PIN_W], hold_data_r};
        mem_we = 1'b1;
        mem_wd = {ode_enc(merged), merged};
        st_nxt = ST_IDLE;
      end
      default:
      begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry read response buffer
  always @*
  begin
    // Half select narrows to the pin width; check bits never leave
    rsp_ent = {dec[`ODE_WORD_W+1:`ODE_WORD_W],
               rsp_half_r ? dec[`ODE_WORD_W-1:`ODE_PIN_W] : dec[`ODE_PIN_W-1:0]};
    q0_nxt  = q0_r;
    q1_nxt  = q1_r;
    cnt_nxt = cnt_r;
    case ({push, pop})
      2'h2:
      begin
        if (cnt_r == `ODE_CNT_ZERO)
        begin
          q0_nxt = rsp_ent;
        end
        else
        begin
          q1_nxt = rsp_ent;
        end
        cnt_nxt = cnt_r + `ODE_CNT_ONE;
      end
      2'h1:
      begin
        q0_nxt  = q1_r;
        q1_nxt  = {`ODE_ENT_W{1'b0}};
        cnt_nxt = cnt_r - `ODE_CNT_ONE;
      end
      2'h3:
      begin
        if (cnt_r == `ODE_CNT_ONE)
        begin
          q0_nxt = rsp_ent;
        end
        else
        begin
          q0_nxt = q1_r;
          q1_nxt = rsp_ent;
        end
      end
      default: cnt_nxt = cnt_r;
    endcase
    wr_ready_nxt = ((st_nxt == ST_IDLE) || (st_nxt == ST_HALF)) && !rep_v_nxt;
    rd_ready_nxt = (st_nxt == ST_IDLE) && !rep_v_nxt &&
                   ((cnt_nxt + {1'b0, rd_take}) < `ODE_CNT_TWO);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers, all on the rising edge of the one clock
  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      st_r        <= ST_IDLE;
      hold_data_r <= {`ODE_PIN_W{1'b0}};
      hold_pair_r <= {PW{1'b0}};
      hold_hi_r   <= 1'b0;
      rep_v_r     <= 1'b0;
      rep_addr_r  <= {ADDR_W{1'b0}};
      rep_data_r  <= {`ODE_PIN_W{1'b0}};
      rsp_pend_r  <= 1'b0;
      rsp_half_r  <= 1'b0;
      wr_ready_r  <= 1'b0;
      rd_ready_r  <= 1'b0;
      q0_r        <= {`ODE_ENT_W{1'b0}};
      q1_r        <= {`ODE_ENT_W{1'b0}};
      cnt_r       <= `ODE_CNT_ZERO;
      dv_r        <= 1'b0;
    end
    else
    begin
      st_r        <= st_nxt;
      hold_data_r <= hold_data_nxt;
      hold_pair_r <= hold_pair_nxt;
      hold_hi_r   <= hold_hi_nxt;
      rep_v_r     <= rep_v_nxt;
      rep_addr_r  <= rep_addr_nxt;
      rep_data_r  <= rep_data_nxt;
      // Read data go only to the buffer, the array keeps its content
      rsp_pend_r  <= rd_take;
      rsp_half_r  <= rd_take ? rd_addr_i[0] : rsp_half_r;
      wr_ready_r  <= wr_ready_nxt;
      rd_ready_r  <= rd_ready_nxt;
      q0_r        <= q0_nxt;
      q1_r        <= q1_nxt;
      cnt_r       <= cnt_nxt;
      dv_r        <= (cnt_nxt != `ODE_CNT_ZERO);
    end
  end

  assign wr_ready_o      = wr_ready_r;
  assign rd_ready_o      = rd_ready_r;
  assign rd_data_o       = q0_r[`ODE_PIN_W-1:0];
  assign rd_corr_o       = q0_r[`ODE_FLG_COR];
  assign rd_uncorr_o     = q0_r[`ODE_FLG_UNC];
  assign rd_data_valid_o = dv_r;

endmodule // ode_ecc_datapath

/* File: ode_ecc_datapath_assertions.sv */
// Port checker for the on-die ECC datapath
`timescale 1ns/100ps
module ode_ecc_datapath_chk #(
  parameter ADDR_W = 24
) (
  input wire              core_clk_i,
  input wire              rst_n_i,
  input wire              wr_valid_i,
  input wire              wr_ready_o,
  input wire [ADDR_W-1:0] wr_addr_i,
  input wire [31:0]       wr_data_i,
  input wire              rd_valid_i,
  input wire              rd_ready_o,
  input wire [ADDR_W-1:0] rd_addr_i,
  input wire [31:0]       rd_data_o,
  input wire              rd_corr_o,
  input wire              rd_uncorr_o,
  input wire              rd_data_valid_o,
  input wire              rd_data_ready_i
);
  wire wr_tk = wr_valid_i && wr_ready_o;
  wire rd_tk = rd_valid_i && rd_ready_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_rst_quiet: assert property (disable iff (1'b0) !rst_n_i |=> !wr_ready_o && !rd_ready_o
    && !rd_data_valid_o) else $error("outputs active during reset");
  a_exit_ready: assert property ($rose(rst_n_i) |=> wr_ready_o && rd_ready_o)
    else $error("not ready after reset");
  a_read_latency: assert property (rd_tk && !rd_data_valid_o |-> ##2 rd_data_valid_o)
    else $error("read data late");
  a_hold_data: assert property (rd_data_valid_o && !rd_data_ready_i |=> rd_data_valid_o
    && $stable(rd_data_o) && $stable({rd_corr_o, rd_uncorr_o})) else $error("read data dropped");
  a_valid_cause: assert property ($rose(rd_data_valid_o) |-> $past(rd_tk, 2))
    else $error("read data without request");
  a_pair_ready: assert property (wr_tk && !wr_addr_i[0] && !$past(wr_tk)
    && $past(wr_ready_o) |=> wr_ready_o) else $error("even half not paired");
  a_lone_rmw: assert property (wr_tk && wr_addr_i[0] && !$past(wr_tk && !wr_addr_i[0])
    && $past(wr_ready_o) |=> !wr_ready_o [*2] ##1 wr_ready_o)
    else $error("lone half write timing");
  a_flags_idle: assert property (!rd_data_valid_o |-> !rd_corr_o && !rd_uncorr_o)
    else $error("error flag without read data");
  a_even_blocks: assert property (wr_tk && !wr_addr_i[0] |=> !rd_ready_o)
    else $error("read taken while half word waits");
endmodule // ode_ecc_datapath_chk

/* File: ode_rd_sink.sv */
// Read-data receiver of the memory controller, prompt or stalling
`timescale 1ns/100ps
module ode_rd_sink (
  input  wire core_clk_i,
  input  wire stall_i,
  output reg  rd_data_ready_o
);
  initial rd_data_ready_o = 1'b0;
  // Ready every cycle, or every other cycle while stalling
  always @(negedge core_clk_i) rd_data_ready_o <= !stall_i || !rd_data_ready_o;
endmodule // ode_rd_sink

/* File: testbench.sv */
// Self-checking testbench of the on-die ECC datapath
`timescale 1ns/100ps
module testbench;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        wr_valid_i = 1'b0;
  logic        rd_valid_i = 1'b0;
  logic        stall = 1'b0;
  logic [5:0]  wr_addr_i = 6'h0;
  logic [5:0]  rd_addr_i = 6'h0;
  logic [31:0] wr_data_i = 32'h0;
  wire         wr_ready_o, rd_ready_o, rd_corr_o, rd_uncorr_o;
  wire         rd_data_valid_o, rd_data_ready_i;
  wire  [31:0] rd_data_o;
  integer      miscompares = 0;
  integer      comparisons = 0;
  logic [33:0] expq[$];
  logic [1:0]  flg = 2'h0;
  always #5 core_clk_i = ~core_clk_i;
  ode_ecc_datapath #(.ADDR_W(6)) DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i), .rd_valid_i(rd_valid_i), .rd_ready_o(rd_ready_o),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_corr_o(rd_corr_o),
    .rd_uncorr_o(rd_uncorr_o), .rd_data_valid_o(rd_data_valid_o),
    .rd_data_ready_i(rd_data_ready_i));
  ode_rd_sink u_sink (.core_clk_i(core_clk_i), .stall_i(stall),
    .rd_data_ready_o(rd_data_ready_i));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Issue one request and hold it until it is taken
  task req(input logic w, input logic [5:0] a, input logic [31:0] d);
    integer n;
    @(negedge core_clk_i);
    wr_valid_i = w;
    rd_valid_i = !w;
    wr_addr_i = a;
    rd_addr_i = a;
    wr_data_i = d;
    n = 0;
    while ((w ? wr_ready_o : rd_ready_o) !== 1'b1 && n < 50)
    begin
      @(negedge core_clk_i);
      n++;
    end
    if (n == 50) chk(34'h0, 34'h1);
    @(posedge core_clk_i);
    if (!w) expq.push_back({flg, d});
  endtask
  task drain;
    integer n;
    @(negedge core_clk_i);
    wr_valid_i = 1'b0;
    rd_valid_i = 1'b0;
    n = 0;
    while ((expq.size() != 0 || rd_data_valid_o !== 1'b0) && n < 100)
    begin
      @(negedge core_clk_i);
      n++;
    end
    if (n == 100) chk(34'h0, 34'h1);
  endtask
  // Every popped word is compared with the oldest outstanding read
  always @(posedge core_clk_i)
    if (rd_data_valid_o === 1'b1 && rd_data_ready_i === 1'b1)
    begin
      if (expq.size() == 0) chk(34'h1, 34'h0);
      else chk({rd_uncorr_o, rd_corr_o, rd_data_o}, expq.pop_front());
    end
  ////////////////////////////////////////////////////////////////////////////////
  // Full pair written back to back, then read half by half
  task t_pair;
    req(1'b1, 6'h00, 32'hA5A5_0F0F);
    req(1'b1, 6'h01, 32'h1234_8001);
    req(1'b0, 6'h00, 32'hA5A5_0F0F);
    req(1'b0, 6'h01, 32'h1234_8001);
    drain;
  endtask
  // Lone odd write, lone even write flushed by a read
  task t_half;
    req(1'b1, 6'h02, 32'hFFFF_FFFF);
    req(1'b1, 6'h03, 32'h0000_0001);
    req(1'b1, 6'h03, 32'hDEAD_0003);
    req(1'b1, 6'h02, 32'h8000_0000);
    req(1'b0, 6'h02, 32'h8000_0000);
    req(1'b0, 6'h03, 32'hDEAD_0003);
    req(1'b1, 6'h00, 32'hA5A5_0F0F);
    req(1'b1, 6'h02, 32'h8000_0000);
    req(1'b0, 6'h00, 32'hA5A5_0F0F);
    req(1'b0, 6'h02, 32'h8000_0000);
    drain;
  endtask
  // Stored bits flipped in the array, then read through the corrector
  task t_flip;
    DUT.u_mem.mem_r[0][3] = ~DUT.u_mem.mem_r[0][3];
    flg = 2'h1;
    req(1'b0, 6'h00, 32'hA5A5_0F0F);
    drain;
    DUT.u_mem.mem_r[0][3] = ~DUT.u_mem.mem_r[0][3];
    DUT.u_mem.mem_r[1][0] = ~DUT.u_mem.mem_r[1][0];
    DUT.u_mem.mem_r[1][1] = ~DUT.u_mem.mem_r[1][1];
    flg = 2'h2;
    req(1'b0, 6'h02, 32'h8000_0003);
    drain;
    DUT.u_mem.mem_r[1][0] = ~DUT.u_mem.mem_r[1][0];
    DUT.u_mem.mem_r[1][1] = ~DUT.u_mem.mem_r[1][1];
    flg = 2'h0;
  endtask
  // Reads pile up in the buffer while the receiver stalls
  task t_stall;
    stall = 1'b1;
    req(1'b0, 6'h00, 32'hA5A5_0F0F);
    req(1'b0, 6'h01, 32'h1234_8001);
    req(1'b0, 6'h02, 32'h8000_0000);
    req(1'b0, 6'h03, 32'hDEAD_0003);
    req(1'b0, 6'h01, 32'h1234_8001);
    drain;
    stall = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    miscompares++;
    stop_test;
  end
  initial
  begin
    repeat (12) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    t_pair;
    t_half;
    t_stall;
    t_flip;
    rst_n_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk({31'h0, wr_ready_o, rd_ready_o, rd_data_valid_o}, 34'h0);
    rst_n_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    t_pair;
    stop_test;
  end
endmodule // testbench
bind ode_ecc_datapath ode_ecc_datapath_chk #(.ADDR_W(ADDR_W)) u_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wr_valid_i(wr_valid_i),
  .wr_ready_o(wr_ready_o), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i),
  .rd_valid_i(rd_valid_i), .rd_ready_o(rd_ready_o), .rd_addr_i(rd_addr_i),
  .rd_data_o(rd_data_o), .rd_corr_o(rd_corr_o), .rd_uncorr_o(rd_uncorr_o),
  .rd_data_valid_o(rd_data_valid_o), .rd_data_ready_i(rd_data_ready_i));
